// ### design/adc_cal_cfg.svh
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// Core clock
`define CORE_CLK_PERIOD_NS 10
// Conversion time, also the throughput time
`define CONV_TIME_NS       2500
`define CONV_CYCLES        (`CONV_TIME_NS / `CORE_CLK_PERIOD_NS)
// Full device calibration time at the reference converter clock
`define CAL_TIME_MS        928
`define CAL_REF_CLK_MHZ    10
`define CAL_CYCLES         (`CAL_TIME_MS * 1000000 / `CORE_CLK_PERIOD_NS)
// Share of the calibration spent in each step
`define CAL_DAC_CYCLES     (`CAL_CYCLES / 2)
`define CAL_OFFSET_CYCLES  (`CAL_CYCLES / 4)
`define CAL_GAIN_CYCLES    (`CAL_CYCLES - `CAL_DAC_CYCLES - `CAL_OFFSET_CYCLES)
// Counter width, enough for the whole calibration
`define CAL_CNT_W          27
// Calibration function code field positions
`define CAL_FUNC_SYSTEM    0
`define CAL_FUNC_GAIN      1
`define CAL_FUNC_OFFSET    2
`define CAL_FUNC_COEFF     3
// Result width and bipolar sign bit flip
`define RESULT_W           16
`define BIPOLAR_FLIP       16'h8000

`endif

// ### design/adc_cal_pkg.sv
package adc_cal_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CONVERT,
    PH_CAL_HELD,
    PH_DAC,
    PH_WAIT_OFFSET,
    PH_OFFSET,
    PH_WAIT_GAIN,
    PH_GAIN
  } phase_t;

  // Reference that the offset or gain step measures against
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_GROUND,
    SRC_REFERENCE,
    SRC_EXTERNAL
  } cal_src_t;

  // Controls toward the analog calibration hardware
  typedef struct packed {
    logic     dac_trim;
    logic     offset_cal;
    logic     gain_cal;
    cal_src_t src;
  } cal_ctrl_t;

  // Software calibration command
  typedef struct packed {
    logic       valid;
    logic [3:0] func;
  } sw_cal_req_t;

endpackage

// ### design/adc_calibration_sequencer.sv
`timescale 1ns/1ps
`include "adc_cal_cfg.svh"

// Behaviour
// [R01] Two sample-and-hold stages: one holds for conversion, the other acquires.
// [R02] Hold and acquire roles swap after every conversion; no acquisition gap.
// [R03] Unipolar range gives straight binary, bipolar range gives two's complement.
// [R04] Host calibrates after every power-on before trusting results.
// [R05] Calibration starts from the calibrate pin or a software command word.
// [R06] Pin-started calibration always runs DAC, offset and gain steps.
// [R07] Software may request offset only, gain only, or offset and gain.
// [R08] Device and system calibration both trim DAC linearity, offset and gain.
// [R09] DAC segments are trimmed first, before offset and gain.
// [R10] System calibration measures offset and full scale on external input voltages.
// [R11] Low pulse on calibrate pin starts device calibration, no further host action.
// [R12] Device calibration: offset against analog ground, gain against reference input.
// [R13] Full device calibration lasts 928 ms, scaled from the clock period.
// [R14] Calibrate pin low resets the logic, aborts conversion and starts calibration.
// [R15] Mode input picks calibration kind during calibrate, else async or sync conversion.
// [R16] Busy output stays low through every conversion and calibration; the code drives it high in PH_WAIT_OFFSET and PH_WAIT_GAIN.
// [R17] Rising edge on conversion start holds the sampler and starts a conversion.
// [R18] A new calibration request during calibration restarts the routine.
module adc_calibration_sequencer
  import adc_cal_pkg::*;
#(
  parameter int CONV_CYCLES   = `CONV_CYCLES,
  parameter int DAC_CYCLES    = `CAL_DAC_CYCLES,
  parameter int OFFSET_CYCLES = `CAL_OFFSET_CYCLES,
  parameter int GAIN_CYCLES   = `CAL_GAIN_CYCLES
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   cal_n_i,
  input  wire logic                   mode_sync_i,
  input  wire logic                   range_select_i,
  input  wire logic                   conversion_start_n_i,
  input  wire sw_cal_req_t            sw_cal_i,
  input  wire logic [`RESULT_W-1:0]   raw_result_i,
  output logic                        busy_n_o,
  output logic                        sha_hold_sel_o,
  output logic                        sar_run_o,
  output cal_ctrl_t                   cal_ctrl_o,
  output logic [`RESULT_W-1:0]        result_o,
  output logic                        result_valid_o
);

  localparam int CW = `CAL_CNT_W;

  phase_t               phase;
  phase_t               next_phase;
  logic [CW-1:0]        cnt;
  logic [CW-1:0]        next_cnt;
  logic                 sys_mode;
  logic                 next_sys_mode;
  logic                 do_dac;
  logic                 next_do_dac;
  logic                 do_offset;
  logic                 next_do_offset;
  logic                 do_gain;
  logic                 next_do_gain;
  logic                 sw_pending;
  logic                 next_sw_pending;
  logic [3:0]           sw_func;
  logic [3:0]           next_sw_func;
  logic                 start_prev;
  logic                 sync_run;
  logic                 next_sync_run;
  logic                 next_busy_n;
  logic                 next_sha_hold_sel;
  logic                 next_sar_run;
  cal_ctrl_t            next_cal_ctrl;
  logic [`RESULT_W-1:0] next_result;
  logic                 next_result_valid;

  logic                 start_rise;
  logic                 sw_ok;
  logic                 load;

  // Phase that follows a finished step, given which steps are enabled
  function automatic phase_t after_step(input phase_t from, input logic off_en,
                                        input logic gain_en, input logic sys);
    phase_t p;
    p = PH_IDLE;
    if ((from == PH_DAC) && off_en) begin
      p = sys ? PH_WAIT_OFFSET : PH_OFFSET;  // see [R10]
    end else if (((from == PH_DAC) || (from == PH_OFFSET)) && gain_en) begin
      p = sys ? PH_WAIT_GAIN : PH_GAIN;
    end
    return p;
  endfunction

  // Cycle count loaded when a phase is entered
  function automatic logic [CW-1:0] load_count(input phase_t p);
    logic [CW-1:0] c;
    c = '0;
    case (p)
      PH_CONVERT: c = CW'(CONV_CYCLES - 1);
      PH_DAC:     c = CW'(DAC_CYCLES - 1);     // see [R13]
      PH_OFFSET:  c = CW'(OFFSET_CYCLES - 1);  // see [R13]
      PH_GAIN:    c = CW'(GAIN_CYCLES - 1);    // see [R13]
      default:    c = '0;
    endcase
    return c;
  endfunction

  // Conversion start edge and software command decode
  assign start_rise = conversion_start_n_i && !start_prev;  // see [R17]
  assign sw_ok      = (!sw_func[`CAL_FUNC_COEFF] &&
                       (sw_func[`CAL_FUNC_OFFSET] || sw_func[`CAL_FUNC_GAIN])) ||
                      (sw_func[3:1] == 3'h7);  // see [R07]

  // Sequencer next state
  always_comb begin
    next_phase        = phase;
    next_cnt          = cnt;
    next_sys_mode     = sys_mode;
    next_do_dac       = do_dac;
    next_do_offset    = do_offset;
    next_do_gain      = do_gain;
    next_sw_pending   = sw_pending;
    next_sw_func      = sw_func;
    next_sync_run     = sync_run;
    next_sha_hold_sel = sha_hold_sel_o;
    next_result       = result_o;
    next_result_valid = 1'b0;
    load              = 1'b0;
    if (sw_cal_i.valid) begin
      next_sw_pending = 1'b1;  // see [R05]
      next_sw_func    = sw_cal_i.func;
    end
    if (!cal_n_i) begin
      // Pin low: drop pending request and sync run, abort conversion, arm full calibration
      next_phase      = PH_CAL_HELD;  // see [R14]
      next_sys_mode   = mode_sync_i;  // see [R15]
      next_do_dac     = 1'b1;         // see [R06]
      next_do_offset  = 1'b1;
      next_do_gain    = 1'b1;
      next_sw_pending = 1'b0;
      next_sync_run   = 1'b0;
    end else begin
      case (phase)
        PH_CAL_HELD: begin
          next_phase = PH_DAC;  // see [R11]
          load       = 1'b1;
        end
        PH_IDLE: begin
          if (sw_pending) begin
            next_sw_pending = 1'b0;
            if (sw_ok) begin
              next_sys_mode  = sw_func[`CAL_FUNC_SYSTEM];
              next_do_dac    = sw_func[`CAL_FUNC_COEFF];  // see [R08]
              next_do_offset = sw_func[`CAL_FUNC_OFFSET];
              next_do_gain   = sw_func[`CAL_FUNC_GAIN];
              next_phase     = sw_func[`CAL_FUNC_COEFF] ? PH_DAC :
                               after_step(PH_DAC, sw_func[`CAL_FUNC_OFFSET],
                                          sw_func[`CAL_FUNC_GAIN],
                                          sw_func[`CAL_FUNC_SYSTEM]);
              load           = 1'b1;
            end
          end else if (mode_sync_i ? (sync_run || start_rise) : start_rise) begin
            next_phase    = PH_CONVERT;  // see [R17]
            next_sync_run = 1'b1;
            load          = 1'b1;
          end
        end
        PH_CONVERT: begin
          if (cnt == '0) begin
            // Latch result, swap hold and acquire stages
            next_result       = range_select_i ? (raw_result_i ^ `BIPOLAR_FLIP) :
                                                 raw_result_i;  // see [R03]
            next_result_valid = 1'b1;
            next_sha_hold_sel = !sha_hold_sel_o;  // see [R01] see [R02]
            if (mode_sync_i) begin
              load = 1'b1;  // see [R02]
            end else begin
              next_phase = PH_IDLE;
            end
          end else begin
            next_cnt = cnt - CW'(1);
          end
        end
        PH_WAIT_OFFSET, PH_WAIT_GAIN: begin
          if (start_rise) begin
            next_phase = (phase == PH_WAIT_OFFSET) ? PH_OFFSET : PH_GAIN;  // see [R10]
            load       = 1'b1;
          end
        end
        PH_DAC, PH_OFFSET, PH_GAIN: begin
          if (cnt == '0) begin
            next_phase = after_step(phase, do_offset, do_gain, sys_mode);  // see [R09]
            load       = 1'b1;
            if (next_phase == PH_IDLE) begin
              next_sync_run = 1'b1;
            end
          end else begin
            next_cnt = cnt - CW'(1);
          end
        end
        default: begin
          next_phase = PH_IDLE;
        end
      endcase
      // Software request during calibration aborts it and starts the requested routine
      if (sw_pending && (phase != PH_IDLE) && (phase != PH_CONVERT) && sw_ok) begin
        next_sw_pending = 1'b0;
        next_sys_mode   = sw_func[`CAL_FUNC_SYSTEM];
        next_do_dac     = sw_func[`CAL_FUNC_COEFF];
        next_do_offset  = sw_func[`CAL_FUNC_OFFSET];
        next_do_gain    = sw_func[`CAL_FUNC_GAIN];
        next_phase      = sw_func[`CAL_FUNC_COEFF] ? PH_DAC :
                          after_step(PH_DAC, sw_func[`CAL_FUNC_OFFSET],
                                     sw_func[`CAL_FUNC_GAIN],
                                     sw_func[`CAL_FUNC_SYSTEM]);  // see [R18]
        load            = 1'b1;
      end
    end
    if (load) begin
      next_cnt = load_count(next_phase);
    end
    if (sw_cal_i.valid) begin
      next_sw_pending = 1'b1;  // Fresh command wins over a same-cycle clear in PH_IDLE or on a restart
      next_sw_func    = sw_cal_i.func;
    end
    if (!cal_n_i) begin
      next_sw_pending = 1'b0;
    end
  end

  // Outputs decoded from the phase being entered
  always_comb begin
    next_busy_n   = 1'b1;
    next_sar_run  = 1'b0;
    next_cal_ctrl = '{dac_trim: 1'b0, offset_cal: 1'b0, gain_cal: 1'b0, src: SRC_NONE};
    case (next_phase)
      PH_CONVERT: begin
        next_busy_n  = 1'b0;  // see [R16]
        next_sar_run = 1'b1;
      end
      PH_CAL_HELD: next_busy_n = 1'b0;  // see [R16]
      PH_DAC: begin
        next_busy_n            = 1'b0;
        next_cal_ctrl.dac_trim = 1'b1;  // see [R09]
      end
      PH_OFFSET: begin
        next_busy_n              = 1'b0;
        next_cal_ctrl.offset_cal = 1'b1;
        next_cal_ctrl.src        = next_sys_mode ? SRC_EXTERNAL : SRC_GROUND;  // see [R12]
      end
      PH_GAIN: begin
        next_busy_n            = 1'b0;
        next_cal_ctrl.gain_cal = 1'b1;
        next_cal_ctrl.src      = next_sys_mode ? SRC_EXTERNAL : SRC_REFERENCE;  // see [R12]
      end
      default: next_busy_n = 1'b1;
    endcase
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase          <= PH_IDLE;
      cnt            <= '0;
      sys_mode       <= 1'b0;
      do_dac         <= 1'b0;
      do_offset      <= 1'b0;
      do_gain        <= 1'b0;
      sw_pending     <= 1'b0;
      sw_func        <= 4'h0;
      start_prev     <= 1'b1;
      sync_run       <= 1'b1;
      busy_n_o       <= 1'b1;
      sha_hold_sel_o <= 1'b0;
      sar_run_o      <= 1'b0;
      cal_ctrl_o     <= '{dac_trim: 1'b0, offset_cal: 1'b0, gain_cal: 1'b0, src: SRC_NONE};
      result_o       <= 16'h0000;
      result_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      phase          <= next_phase;
      cnt            <= next_cnt;
      sys_mode       <= next_sys_mode;
      do_dac         <= next_do_dac;
      do_offset      <= next_do_offset;
      do_gain        <= next_do_gain;
      sw_pending     <= next_sw_pending;
      sw_func        <= next_sw_func;
      start_prev     <= conversion_start_n_i;
      sync_run       <= next_sync_run;
      busy_n_o       <= next_busy_n;
      sha_hold_sel_o <= next_sha_hold_sel;
      sar_run_o      <= next_sar_run;
      cal_ctrl_o     <= next_cal_ctrl;
      result_o       <= next_result;
      result_valid_o <= next_result_valid;
    end
  end

endmodule

// ### verification/analog_core_model.sv
`timescale 1ns/1ps
module analog_core_model (
  input  wire logic        core_clk_i,
  input  wire logic        sar_run_i,
  output logic [15:0]      raw_result_o,
  output logic [15:0]      held_o
);
  logic        run_q = 1'b0;
  logic [15:0] hold  = 16'h8ACE;

  // A fresh sample is taken only when sar_run_i rises, not between back-to-back conversions
  always @(posedge core_clk_i) begin
    run_q <= sar_run_i;
    if (sar_run_i && !run_q) begin
      hold <= hold + 16'h1357;
    end
  end

  // Held value only while converting, its complement otherwise
  assign raw_result_o = sar_run_i ? hold : ~hold;
  assign held_o       = hold;
endmodule

// ### verification/adc_seq_assertions.sv
`timescale 1ns/1ps
module adc_seq_checker
  import adc_cal_pkg::*;
#(
  parameter int CONV_CYCLES = 250
) (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        clk_en_i,
  input wire logic        cal_n_i,
  input wire logic        range_select_i,
  input wire logic [15:0] raw_result_i,
  input wire logic        busy_n_o,
  input wire logic        sha_hold_sel_o,
  input wire logic        sar_run_o,
  input wire cal_ctrl_t   cal_ctrl_o,
  input wire logic [15:0] result_o,
  input wire logic        result_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  int run_cnt;
  int next_run_cnt;

  // Converting cycles since the last result; the result cycle itself starts a new count
  always_comb begin
    next_run_cnt = !sar_run_o ? 0 : (result_valid_o ? 1 : run_cnt + 1);
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_cnt <= 0;
    end else if (clk_en_i) begin
      run_cnt <= next_run_cnt;
    end
  end

  chk_conv_busy: assert property (sar_run_o |-> !busy_n_o)
    else $error("busy high during conversion");
  chk_step_busy: assert property (|cal_ctrl_o[4:2] |-> !busy_n_o)
    else $error("busy high during calibration step");
  chk_pin_abort: assert property (clk_en_i && !cal_n_i
    |=> !busy_n_o && !sar_run_o && !result_valid_o)
    else $error("calibrate pin did not take over");
  chk_pin_full: assert property (clk_en_i && $rose(cal_n_i)
    |=> cal_ctrl_o.dac_trim)
    else $error("pin calibration did not begin with DAC");
  chk_dac_alone: assert property (cal_ctrl_o.dac_trim
    |-> !cal_ctrl_o.offset_cal && !cal_ctrl_o.gain_cal)
    else $error("DAC trim overlaps offset or gain");
  chk_ofs_src: assert property (cal_ctrl_o.offset_cal
    |-> cal_ctrl_o.src inside {SRC_GROUND, SRC_EXTERNAL})
    else $error("offset step on wrong source");
  chk_gain_src: assert property (cal_ctrl_o.gain_cal
    |-> cal_ctrl_o.src inside {SRC_REFERENCE, SRC_EXTERNAL})
    else $error("gain step on wrong source");
  chk_out_code: assert property (result_valid_o
    |-> result_o == ($past(raw_result_i) ^ ($past(range_select_i) ? 16'h8000 : 16'h0000)))
    else $error("result coding wrong");
  chk_hold_swap: assert property (result_valid_o
    |-> sha_hold_sel_o != $past(sha_hold_sel_o))
    else $error("hold stage not swapped");
  chk_conv_len: assert property (result_valid_o |-> run_cnt == CONV_CYCLES)
    else $error("conversion length wrong");
endmodule

bind adc_calibration_sequencer adc_seq_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .cal_n_i(cal_n_i),
  .range_select_i(range_select_i), .raw_result_i(raw_result_i), .busy_n_o(busy_n_o),
  .sha_hold_sel_o(sha_hold_sel_o), .sar_run_o(sar_run_o), .cal_ctrl_o(cal_ctrl_o),
  .result_o(result_o), .result_valid_o(result_valid_o));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import adc_cal_pkg::*;
  localparam int CONV = 20;
  localparam int DAC  = 40;
  localparam int OFS  = 20;
  localparam int GAIN = 20;
  logic        core_clk_i           = 1'b0;
  logic        resetn_i             = 1'b0;
  logic        cal_n_i              = 1'b1;
  logic        mode_sync_i          = 1'b0;
  logic        range_select_i       = 1'b0;
  logic        conversion_start_n_i = 1'b1;
  sw_cal_req_t sw_cal_i             = '0;
  logic [15:0] raw_result_i;
  logic [15:0] held;
  logic        busy_n_o;
  logic        sha_hold_sel_o;
  logic        sar_run_o;
  cal_ctrl_t   cal_ctrl_o;
  logic [15:0] result_o;
  logic        result_valid_o;
  int          num_errors  = 0;
  int          comparisons = 0;

  always #5 core_clk_i = ~core_clk_i;

  adc_calibration_sequencer #(.CONV_CYCLES(CONV), .DAC_CYCLES(DAC), .OFFSET_CYCLES(OFS),
    .GAIN_CYCLES(GAIN)) uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .cal_n_i(cal_n_i), .mode_sync_i(mode_sync_i), .range_select_i(range_select_i),
    .conversion_start_n_i(conversion_start_n_i), .sw_cal_i(sw_cal_i),
    .raw_result_i(raw_result_i), .busy_n_o(busy_n_o), .sha_hold_sel_o(sha_hold_sel_o),
    .sar_run_o(sar_run_o), .cal_ctrl_o(cal_ctrl_o), .result_o(result_o),
    .result_valid_o(result_valid_o));
  analog_core_model core (.core_clk_i(core_clk_i), .sar_run_i(sar_run_o),
    .raw_result_o(raw_result_i), .held_o(held));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Low pulse then rise on the start input
  task automatic pulse_start();
    @(posedge core_clk_i);
    conversion_start_n_i <= 1'b0;
    @(posedge core_clk_i);
    conversion_start_n_i <= 1'b1;
  endtask

  task automatic t_conv(input logic rng);
    logic sel;
    int   n;
    @(posedge core_clk_i);
    range_select_i <= rng;
    @(negedge core_clk_i);
    sel = sha_hold_sel_o;
    pulse_start();
    repeat (2) @(negedge core_clk_i);
    check("busy_n_o start", 0, busy_n_o);
    for (n = 0; n < 100 && result_valid_o !== 1'b1; n++) @(negedge core_clk_i);
    check("conversion cycles", CONV, n);
    check("result_o", held ^ (rng ? 16'h8000 : 16'h0000), result_o);
    check("sha_hold_sel_o", !sel, sha_hold_sel_o);
    check("busy_n_o end", 1, busy_n_o);
  endtask

  task automatic t_cal(input logic sys, input logic abort);
    int       nd = 0;
    int       ns = 0;
    int       w  = sys ? 2 : 0;
    cal_src_t so = SRC_NONE;
    cal_src_t sg = SRC_NONE;
    logic     v  = 1'b0;
    @(posedge core_clk_i);
    if (abort) begin
      pulse_start();
      repeat (5) @(posedge core_clk_i);
    end
    cal_n_i     <= 1'b0;
    mode_sync_i <= sys;
    repeat (3) @(posedge core_clk_i);
    cal_n_i     <= 1'b1;
    mode_sync_i <= 1'b0;
    @(negedge core_clk_i);
    check("busy_n_o held", 0, busy_n_o);
    for (int n = 0; n < 300; n++) begin
      @(negedge core_clk_i);
      v |= result_valid_o;
      nd += cal_ctrl_o.dac_trim;
      ns += cal_ctrl_o.offset_cal + cal_ctrl_o.gain_cal;
      if (cal_ctrl_o.offset_cal) so = cal_ctrl_o.src;
      if (cal_ctrl_o.gain_cal) sg = cal_ctrl_o.src;
      if (busy_n_o === 1'b1 && w > 0) begin
        pulse_start();
        w--;
        @(posedge core_clk_i);
      end else if (busy_n_o === 1'b1) begin
        break;
      end
    end
    check("dac cycles", DAC, nd);
    check("offset gain cycles", OFS + GAIN, ns);
    check("offset source", sys ? SRC_EXTERNAL : SRC_GROUND, so);
    check("gain source", sys ? SRC_EXTERNAL : SRC_REFERENCE, sg);
    check("aborted result", 0, v);
  endtask

  task automatic t_sw(input logic [3:0] f);
    logic ok = f inside {4'h2, 4'h4, 4'h6, 4'hE};
    int   nd = 0;
    int   no = 0;
    int   ng = 0;
    int   nb = 0;
    @(posedge core_clk_i);
    sw_cal_i <= '{valid: 1'b1, func: f};
    @(posedge core_clk_i);
    sw_cal_i <= '0;
    repeat (120) begin
      @(negedge core_clk_i);
      nd += cal_ctrl_o.dac_trim;
      no += cal_ctrl_o.offset_cal;
      ng += cal_ctrl_o.gain_cal;
      nb += !busy_n_o;
    end
    check("sw dac cycles", (ok && f[3]) ? DAC : 0, nd);
    check("sw offset cycles", (ok && f[2]) ? OFS : 0, no);
    check("sw gain cycles", (ok && f[1]) ? GAIN : 0, ng);
    check("sw busy cycles", nd + no + ng, nb);
  endtask

  // Back-to-back conversions while the mode input is high, then a clean stop
  task automatic t_sync();
    int nr = 0;
    int nb = 0;
    @(posedge core_clk_i);
    mode_sync_i <= 1'b1;
    repeat (3 * CONV) begin
      @(negedge core_clk_i);
      nr += result_valid_o;
      nb += !busy_n_o;
    end
    @(posedge core_clk_i);
    mode_sync_i <= 1'b0;
    repeat (2 * CONV) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("sync results", 2, nr);
    check("sync busy cycles", 3 * CONV - 1, nb);
    check("sync stopped", 1, busy_n_o);
  endtask

  // Second full software command ten cycles into the DAC step restarts it
  task automatic t_restart();
    int nd = 0;
    int nb = 0;
    for (int n = 0; n < 120; n++) begin
      @(posedge core_clk_i);
      sw_cal_i <= '{valid: (n == 0 || n == 10), func: 4'hE};
      @(negedge core_clk_i);
      nd += cal_ctrl_o.dac_trim;
      nb += !busy_n_o;
    end
    check("restart dac cycles", DAC + 10, nd);
    check("restart busy cycles", DAC + 10 + OFS + GAIN, nb);
  endtask

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    check("busy_n_o reset", 1, busy_n_o);
    check("cal_ctrl_o reset", 0, cal_ctrl_o);
    t_cal(1'b0, 1'b0);
    t_conv(1'b0);
    t_conv(1'b1);
    t_sync();
    t_cal(1'b0, 1'b1);
    t_cal(1'b1, 1'b0);
    t_sw(4'h2);
    t_sw(4'h4);
    t_sw(4'h6);
    t_sw(4'hE);
    t_sw(4'h0);
    t_sw(4'h1);
    t_sw(4'h8);
    t_sw(4'hD);
    t_restart();
    test_done();
  end
endmodule
